/* File: shared/fsps_defs.svh */
/*
 * Constants of the flash self-program sequencer: register map, key
 * values, reset values and operation timing.
 * Assumes a 100 MHz instruction clock and an 8-bit register port.
 */
// Operation
// - Second instruction cycle after read request is used for the fetch.
// - Fetched word sits in data pair the cycle after the fetch.
// - Data pair holds the word until another read or software write.
// - Read and write bits are set-only; hardware clears them on completion.
// - Erase, latch load and program run only after a complete unlock.
// - Setting write bit after valid unlock forces two no-operation slots.
// - Row erase or program stalls execution about 2 ms, then continues.
// - Latch load only forces two no-operations, no stall.
// - Erase acts on whole rows; any address in the row selects it.
// - During erase halt clocks and peripherals keep running, not sleep.
// - After erase, execution resumes at third instruction after write bit.
// - Write allowed only with write enable set; it is clear after reset.
// - Unlock key register is write-only and reads as zero.
// - A broken unlock starts neither latch load nor program write.
`ifndef FSPS_DEFS_SVH
`define FSPS_DEFS_SVH

// ****************************************
// Register port
// ****************************************
`define FSPS_ADDR_W          3
`define FSPS_DATA_W          8
`define FSPS_ADR_ADDR_LOW    3'h0
`define FSPS_ADR_ADDR_HIGH   3'h1
`define FSPS_ADR_DATA_LOW    3'h2
`define FSPS_ADR_DATA_HIGH   3'h3
`define FSPS_ADR_CONTROL     3'h4
`define FSPS_ADR_UNLOCK_KEY  3'h5

// ****************************************
// Flash geometry
// ****************************************
`define FSPS_FADDR_W         15
`define FSPS_FDATA_W         14
`define FSPS_ADDR_HI_W       7
`define FSPS_DATA_HI_W       6
`define FSPS_ROW_BITS        5
`define FSPS_ROW_MASK        5'h00

// ****************************************
// Unlock keys and reset values
// ****************************************
`define FSPS_KEY_FIRST       8'h55
`define FSPS_KEY_SECOND      8'haa
`define FSPS_BYTE_ZERO       8'h00
`define FSPS_ADDR_RST        15'h0000
`define FSPS_DATA_RST        14'h0000

// ****************************************
// Timing
// ****************************************
`define FSPS_CLK_PERIOD_NS   10
`define FSPS_OP_TIME_MS      2
`define FSPS_NS_PER_MS       1000000
`define FSPS_OP_CNT_W        18
`define FSPS_CNT_ONE         18'h00001

`endif

/* File: shared/fsps_pkg.sv */
/*
 * Types of the flash self-program sequencer.
 * Assumes fsps_defs.svh is on the include path.
 */
`include "fsps_defs.svh"

package fsps_pkg;

	// ****************************************
	// Control register layout
	// ****************************************
	typedef struct packed {
		logic spare;
		logic config_space_select;
		logic load_latches_only;
		logic erase_select;
		logic write_error_flag;
		logic write_enable_bit;
		logic wr;
		logic rd;
	} fsps_ctrl_t;

	typedef struct packed {
		logic [`FSPS_ADDR_W-1:0] addr;
		logic [`FSPS_DATA_W-1:0] wdata;
		logic                    wr;
		logic                    rd;
	} fsps_bus_t;

	// ****************************************
	// State machines
	// ****************************************
	typedef enum logic [2:0] {
		FSPS_IDLE     = 3'h0,
		FSPS_RD_ISSUE = 3'h1,
		FSPS_RD_CAPT  = 3'h3,
		FSPS_WR_NOP1  = 3'h2,
		FSPS_WR_NOP2  = 3'h6,
		FSPS_WR_STALL = 3'h7
	} fsps_state_t;

	typedef enum logic [1:0] {
		FSPS_UL_IDLE  = 2'h0,
		FSPS_UL_KEY1  = 2'h1,
		FSPS_UL_ARMED = 2'h3
	} fsps_ul_state_t;

endpackage

/* File: hw/fsps_unlock.sv */
/*
 * Unlock sequence detector: tracks the two key writes.
 * Assumes bus strobes from logic on the same clock.
 */
`timescale 1ns/1ps
`include "fsps_defs.svh"

module fsps_unlock
(
	input  wire logic                      i_clk,
	input  wire logic                      i_rst,
	input  wire logic                      i_key_wr,
	input  wire logic [`FSPS_DATA_W-1:0]   i_key_data,
	input  wire logic                      i_any_strobe,
	output logic                           o_armed
);
	import fsps_pkg::*;

	fsps_ul_state_t state_q;
	fsps_ul_state_t state_d;

	// ****************************************
	// Key tracking
	// ****************************************
	always_comb
	begin
		state_d = state_q;
		if (i_key_wr && i_key_data == `FSPS_KEY_FIRST)
			state_d = FSPS_UL_KEY1;
		else if (i_key_wr && i_key_data == `FSPS_KEY_SECOND && state_q == FSPS_UL_KEY1)
			state_d = FSPS_UL_ARMED;
		else if (i_any_strobe)
			state_d = FSPS_UL_IDLE;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			state_q <= FSPS_UL_IDLE;
		else
			state_q <= state_d;
	end

	assign o_armed = (state_q == FSPS_UL_ARMED);

	// ****************************************
	// Checks
	// ****************************************
	property p_ul_break;
		@(posedge i_clk) disable iff (i_rst)
		(i_any_strobe && !i_key_wr) |=> !o_armed;
	endproperty
	a_ul_break: assert property (p_ul_break) else $error("unlock kept after other access");

	property p_ul_arm;
		@(posedge i_clk) disable iff (i_rst)
		$rose(o_armed) |-> $past(i_key_wr) && $past(i_key_data) == `FSPS_KEY_SECOND;
	endproperty
	a_ul_arm: assert property (p_ul_arm) else $error("armed without second key");

endmodule

/* File: hw/fsps_top.sv */
/*
 * Flash self-program sequencer: address/data pair, control and unlock
 * registers, single word read, latch load, row program and row erase.
 * Assumes the core issues one register strobe per instruction cycle, the
 * flash array returns a word one cycle after its read strobe, and the core
 * honours the forced no-operation and stall outputs.
 */
`timescale 1ns/1ps
`include "fsps_defs.svh"

module fsps_top
#(
	parameter logic [`FSPS_OP_CNT_W-1:0] P_OP_CYCLES =
		`FSPS_OP_CNT_W'(`FSPS_OP_TIME_MS * `FSPS_NS_PER_MS / `FSPS_CLK_PERIOD_NS)
)
(
	input  wire logic                         I_SYS_CLK,
	input  wire logic                         I_RST,
	input  wire logic [`FSPS_ADDR_W-1:0]      I_ADDR,
	input  wire logic [`FSPS_DATA_W-1:0]      I_WDATA,
	input  wire logic                         I_WR,
	input  wire logic                         I_RD,
	output logic      [`FSPS_DATA_W-1:0]      O_RDATA,
	input  wire logic [`FSPS_FDATA_W-1:0]     I_FLASH_RDATA,
	output logic                              O_FLASH_RD,
	output logic      [`FSPS_FADDR_W-1:0]     O_FLASH_ADDR,
	output logic      [`FSPS_FDATA_W-1:0]     O_FLASH_WDATA,
	output logic                              O_CFG_SPACE,
	output logic                              O_LATCH_LOAD,
	output logic                              O_PROG_START,
	output logic                              O_ERASE_START,
	output logic                              O_FORCE_NOP,
	output logic                              O_STALL
);
	import fsps_pkg::*;

	// ****************************************
	// Decoding
	// ****************************************
	function automatic logic hit(input fsps_bus_t b, input logic [`FSPS_ADDR_W-1:0] a,
		input logic is_wr);
		hit = (is_wr ? b.wr : b.rd) && b.addr == a;
	endfunction

	fsps_bus_t                      bus;
	fsps_ctrl_t                     wd;
	logic                           armed;

	assign bus = '{addr: I_ADDR, wdata: I_WDATA, wr: I_WR, rd: I_RD};
	assign wd  = fsps_ctrl_t'(I_WDATA);

	// ****************************************
	// State
	// ****************************************
	fsps_state_t                    state_q;
	fsps_state_t                    state_d;
	fsps_ctrl_t                     ctrl_q;
	fsps_ctrl_t                     ctrl_d;
	logic [`FSPS_FADDR_W-1:0]       addr_q;
	logic [`FSPS_FADDR_W-1:0]       addr_d;
	logic [`FSPS_FADDR_W-1:0]       flash_addr_q;
	logic [`FSPS_FADDR_W-1:0]       flash_addr_d;
	logic [`FSPS_FDATA_W-1:0]       data_q;
	logic [`FSPS_FDATA_W-1:0]       data_d;
	logic [`FSPS_OP_CNT_W-1:0]      cnt_q;
	logic [`FSPS_OP_CNT_W-1:0]      cnt_d;
	logic [`FSPS_DATA_W-1:0]        rdata_q;
	logic [`FSPS_DATA_W-1:0]        rdata_d;
	logic                           flash_rd_q;
	logic                           flash_rd_d;
	logic                           latch_q;
	logic                           latch_d;
	logic                           prog_q;
	logic                           prog_d;
	logic                           erase_q;
	logic                           erase_d;
	logic                           nop_q;
	logic                           nop_d;
	logic                           stall_q;
	logic                           stall_d;
	logic                           ctrl_wr;
	logic                           wr_start;
	logic                           rd_start;

	fsps_unlock u_unlock
	(
		.i_clk        (I_SYS_CLK),
		.i_rst        (I_RST),
		.i_key_wr     (hit(bus, `FSPS_ADR_UNLOCK_KEY, 1'b1)),
		.i_key_data   (I_WDATA),
		.i_any_strobe (I_WR | I_RD),
		.o_armed      (armed)
	);

	assign ctrl_wr  = hit(bus, `FSPS_ADR_CONTROL, 1'b1);
	// Write bit only after unlock and with writes enabled
	assign wr_start = ctrl_wr && wd.wr && armed && wd.write_enable_bit
		&& state_q == FSPS_IDLE;
	assign rd_start = ctrl_wr && wd.rd && !wr_start && state_q == FSPS_IDLE;

	// ****************************************
	// Sequencer
	// ****************************************
	always_comb
	begin
		state_d = state_q;
		cnt_d   = cnt_q;
		unique case (state_q)
			FSPS_IDLE:
			begin
				if (wr_start)
					state_d = FSPS_WR_NOP1;
				else if (rd_start)
					state_d = FSPS_RD_ISSUE;
			end
			FSPS_RD_ISSUE:
				state_d = FSPS_RD_CAPT;
			FSPS_RD_CAPT:
				state_d = FSPS_IDLE;
			FSPS_WR_NOP1:
				state_d = FSPS_WR_NOP2;
			FSPS_WR_NOP2:
			begin
				cnt_d = '0;
				// Latch load goes on without stall
				if (ctrl_q.load_latches_only && !ctrl_q.erase_select)
					state_d = FSPS_IDLE;
				else
					state_d = FSPS_WR_STALL;
			end
			FSPS_WR_STALL:
			begin
				// Counter keeps running on the live clock; only fetch halts
				if (cnt_q == P_OP_CYCLES - `FSPS_CNT_ONE)
					state_d = FSPS_IDLE;
				else
					cnt_d = cnt_q + `FSPS_CNT_ONE;
			end
			default:
				state_d = FSPS_IDLE;
		endcase
	end

	// ****************************************
	// Registers and side effects
	// ****************************************
	always_comb
	begin
		ctrl_d = ctrl_q;
		addr_d = addr_q;
		data_d = data_q;
		if (hit(bus, `FSPS_ADR_ADDR_LOW, 1'b1))
			addr_d[`FSPS_DATA_W-1:0] = I_WDATA;
		if (hit(bus, `FSPS_ADR_ADDR_HIGH, 1'b1))
			addr_d[`FSPS_FADDR_W-1:`FSPS_DATA_W] = I_WDATA[`FSPS_ADDR_HI_W-1:0];
		if (hit(bus, `FSPS_ADR_DATA_LOW, 1'b1))
			data_d[`FSPS_DATA_W-1:0] = I_WDATA;
		if (hit(bus, `FSPS_ADR_DATA_HIGH, 1'b1))
			data_d[`FSPS_FDATA_W-1:`FSPS_DATA_W] = I_WDATA[`FSPS_DATA_HI_W-1:0];
		if (ctrl_wr)
		begin
			ctrl_d.config_space_select = wd.config_space_select;
			ctrl_d.load_latches_only   = wd.load_latches_only;
			ctrl_d.erase_select        = wd.erase_select;
			ctrl_d.write_error_flag    = wd.write_error_flag;
			ctrl_d.write_enable_bit    = wd.write_enable_bit;
		end
		// Set-only from software
		if (wr_start)
			ctrl_d.wr = 1'b1;
		if (rd_start)
			ctrl_d.rd = 1'b1;
		if (state_q == FSPS_RD_CAPT)
		begin
			data_d    = I_FLASH_RDATA;
			ctrl_d.rd = 1'b0;
		end
		if (state_q != FSPS_IDLE && state_d == FSPS_IDLE && ctrl_q.wr)
			ctrl_d.wr = 1'b0;
		ctrl_d.spare = 1'b0;
	end

	always_comb
	begin
		rdata_d = `FSPS_BYTE_ZERO;
		if (I_RD)
		begin
			unique case (I_ADDR)
				`FSPS_ADR_ADDR_LOW:  rdata_d = addr_q[`FSPS_DATA_W-1:0];
				`FSPS_ADR_ADDR_HIGH: rdata_d = {1'b0, addr_q[`FSPS_FADDR_W-1:`FSPS_DATA_W]};
				`FSPS_ADR_DATA_LOW:  rdata_d = data_q[`FSPS_DATA_W-1:0];
				`FSPS_ADR_DATA_HIGH: rdata_d = {2'b00, data_q[`FSPS_FDATA_W-1:`FSPS_DATA_W]};
				`FSPS_ADR_CONTROL:   rdata_d = ctrl_q;
				default:             rdata_d = `FSPS_BYTE_ZERO;
			endcase
		end
	end

	always_comb
	begin
		flash_rd_d = (state_d == FSPS_RD_ISSUE);
		// Second slot after read request and both slots after write bit
		nop_d      = (state_d == FSPS_RD_CAPT) || (state_d == FSPS_WR_NOP1)
			|| (state_d == FSPS_WR_NOP2);
		stall_d    = (state_d == FSPS_WR_STALL);
		latch_d    = (state_d == FSPS_WR_NOP1) && ctrl_d.load_latches_only
			&& !ctrl_d.erase_select;
		erase_d    = (state_q == FSPS_WR_NOP2) && (state_d == FSPS_WR_STALL)
			&& ctrl_q.erase_select;
		prog_d     = (state_q == FSPS_WR_NOP2) && (state_d == FSPS_WR_STALL)
			&& !ctrl_q.erase_select;
		// Erase sees the row base; low bits only pick a latch
		flash_addr_d = erase_d ? {addr_d[`FSPS_FADDR_W-1:`FSPS_ROW_BITS], `FSPS_ROW_MASK}
			: addr_d;
	end

	always_ff @(posedge I_SYS_CLK)
	begin
		if (I_RST)
		begin
			state_q    <= FSPS_IDLE;
			// Reset of one cycle that cuts an erase or program leaves the error flag; a longer reset clears it
			ctrl_q     <= '{write_error_flag: ctrl_q.wr, default: 1'b0};
			addr_q     <= `FSPS_ADDR_RST;
			data_q     <= `FSPS_DATA_RST;
			cnt_q      <= '0;
			rdata_q    <= `FSPS_BYTE_ZERO;
			flash_rd_q <= 1'b0;
			latch_q    <= 1'b0;
			prog_q     <= 1'b0;
			erase_q    <= 1'b0;
			nop_q      <= 1'b0;
			stall_q    <= 1'b0;
			flash_addr_q <= `FSPS_ADDR_RST;
		end
		else
		begin
			state_q    <= state_d;
			ctrl_q     <= ctrl_d;
			addr_q     <= addr_d;
			data_q     <= data_d;
			cnt_q      <= cnt_d;
			rdata_q    <= rdata_d;
			flash_rd_q <= flash_rd_d;
			latch_q    <= latch_d;
			prog_q     <= prog_d;
			erase_q    <= erase_d;
			nop_q      <= nop_d;
			stall_q    <= stall_d;
			flash_addr_q <= flash_addr_d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign O_RDATA       = rdata_q;
	assign O_FLASH_RD    = flash_rd_q;
	assign O_FLASH_ADDR  = flash_addr_q;
	assign O_FLASH_WDATA = data_q;
	assign O_CFG_SPACE   = ctrl_q.config_space_select;
	assign O_LATCH_LOAD  = latch_q;
	assign O_PROG_START  = prog_q;
	assign O_ERASE_START = erase_q;
	assign O_FORCE_NOP   = nop_q;
	assign O_STALL       = stall_q;

	// ****************************************
	// Checks
	// ****************************************
	logic [`FSPS_OP_CNT_W-1:0] stall_len_q;

	always_ff @(posedge I_SYS_CLK)
	begin
		if (I_RST || !O_STALL)
			stall_len_q <= '0;
		else
			stall_len_q <= stall_len_q + `FSPS_CNT_ONE;
	end

	property p_rd_slot;
		@(posedge I_SYS_CLK) disable iff (I_RST)
		rd_start |=> O_FLASH_RD && !O_FORCE_NOP ##1 O_FORCE_NOP && !O_FLASH_RD;
	endproperty
	a_rd_slot: assert property (p_rd_slot) else $error("read fetch slot wrong");

	property p_rd_data;
		@(posedge I_SYS_CLK) disable iff (I_RST)
		O_FLASH_RD |=> ##1 O_FLASH_WDATA == $past(I_FLASH_RDATA);
	endproperty
	a_rd_data: assert property (p_rd_data) else $error("read word not captured");

	property p_data_hold;
		@(posedge I_SYS_CLK) disable iff (I_RST)
		(state_q != FSPS_RD_CAPT && !hit(bus, `FSPS_ADR_DATA_LOW, 1'b1)
			&& !hit(bus, `FSPS_ADR_DATA_HIGH, 1'b1)) |=> $stable(data_q);
	endproperty
	a_data_hold: assert property (p_data_hold) else $error("data pair changed");

	property p_bits_set_only;
		@(posedge I_SYS_CLK) disable iff (I_RST)
		(ctrl_q.rd || ctrl_q.wr) && state_q != FSPS_RD_CAPT && state_d != FSPS_IDLE
			|=> (ctrl_q.rd || ctrl_q.wr);
	endproperty
	a_bits_set_only: assert property (p_bits_set_only) else $error("bit cleared early");

	property p_wr_nops;
		@(posedge I_SYS_CLK) disable iff (I_RST)
		wr_start |=> O_FORCE_NOP [*2] ##1 !O_FORCE_NOP;
	endproperty
	a_wr_nops: assert property (p_wr_nops) else $error("forced no-ops wrong");

	property p_stall_len;
		@(posedge I_SYS_CLK) disable iff (I_RST)
		$fell(O_STALL) && !$past(I_RST) |-> $past(stall_len_q) == P_OP_CYCLES - `FSPS_CNT_ONE;
	endproperty
	a_stall_len: assert property (p_stall_len) else $error("stall length wrong");

	property p_latch_no_stall;
		@(posedge I_SYS_CLK) disable iff (I_RST)
		O_LATCH_LOAD |-> ##2 !O_STALL && !O_FORCE_NOP && !ctrl_q.wr;
	endproperty
	a_latch_no_stall: assert property (p_latch_no_stall) else $error("latch load stalled");

	property p_erase_row;
		@(posedge I_SYS_CLK) disable iff (I_RST)
		O_ERASE_START |-> O_FLASH_ADDR[`FSPS_ROW_BITS-1:0] == `FSPS_ROW_MASK && O_STALL;
	endproperty
	a_erase_row: assert property (p_erase_row) else $error("erase not row aligned");

	property p_resume;
		@(posedge I_SYS_CLK) disable iff (I_RST)
		$fell(O_STALL) |-> state_q == FSPS_IDLE && !ctrl_q.wr && !O_FORCE_NOP;
	endproperty
	a_resume: assert property (p_resume) else $error("no clean resume");

	property p_write_enable_bit_gate;
		@(posedge I_SYS_CLK) disable iff (I_RST)
		$rose(ctrl_q.wr) |-> ctrl_q.write_enable_bit && $past(armed);
	endproperty
	a_write_enable_bit_gate: assert property (p_write_enable_bit_gate) else $error("write without enable");

	property p_key_reads_zero;
		@(posedge I_SYS_CLK) disable iff (I_RST)
		hit(bus, `FSPS_ADR_UNLOCK_KEY, 1'b0) |=> O_RDATA == `FSPS_BYTE_ZERO;
	endproperty
	a_key_reads_zero: assert property (p_key_reads_zero) else $error("key read nonzero");

	property p_no_op_unlocked;
		@(posedge I_SYS_CLK) disable iff (I_RST)
		O_LATCH_LOAD |-> $past(armed) && $past(ctrl_wr);
	endproperty
	a_no_op_unlocked: assert property (p_no_op_unlocked) else $error("op without unlock");

	property p_no_run_unlocked;
		@(posedge I_SYS_CLK) disable iff (I_RST)
		(O_PROG_START || O_ERASE_START) |-> $past(armed, 3) && $past(ctrl_wr, 3);
	endproperty
	a_no_run_unlocked: assert property (p_no_run_unlocked) else $error("run without unlock");

	property p_clock_runs;
		@(posedge I_SYS_CLK) disable iff (I_RST)
		O_STALL && $past(O_STALL) |-> cnt_q == $past(cnt_q) + `FSPS_CNT_ONE;
	endproperty
	a_clock_runs: assert property (p_clock_runs) else $error("halt froze timing");

endmodule

/* File: bench/fsps_flash_model.sv */
/*
 * Flash array model that answers the sequencer's word fetches.
 * Assumes a one-cycle fetch strobe on the sequencer's clock and that
 * the word is taken in the cycle after that strobe.
 */
`timescale 1ns/1ps
`include "fsps_defs.svh"

module fsps_flash_model
(
	input  wire logic                      i_clk,
	input  wire logic                      i_rd,
	input  wire logic [`FSPS_FADDR_W-1:0]  i_addr,
	output logic      [`FSPS_FDATA_W-1:0]  o_rdata
);
	// ****************************************
	// Fetch answer
	// ****************************************
	initial o_rdata = 14'h0000;

	// Word valid only in the cycle after the fetch strobe; otherwise the lines churn
	always @(posedge i_clk)
	begin
		if (i_rd)
			o_rdata <= i_addr[13:0] ^ 14'h2c5a;
		else
			o_rdata <= ~o_rdata ^ 14'h0001;
	end
endmodule

/* File: bench/fsps_top_bench.sv */
/*
 * Self-checking bench of the flash self-program sequencer.
 * Assumes fsps_pkg, fsps_top and fsps_flash_model are compiled before it.
 */
`timescale 1ns/1ps
`include "fsps_defs.svh"

module fsps_top_bench;
	import fsps_pkg::*;

	typedef struct packed {
		logic [2:0] a;
		logic [7:0] w;
		logic [7:0] e;
	} fsps_row_t;

	localparam logic [`FSPS_OP_CNT_W-1:0] OP_CYC = 18'h00008;
	localparam int                        OP_N   = 8;

	logic        sys_clk;
	logic        rst;
	logic [2:0]  addr;
	logic [7:0]  wdata;
	logic        wr;
	logic        rd;
	logic [7:0]  rdata;
	logic [13:0] flash_rdata;
	logic        flash_rd;
	logic [14:0] flash_addr;
	logic [13:0] flash_wdata;
	logic        cfg_space;
	logic        latch_load;
	logic        prog_start;
	logic        erase_start;
	logic        force_nop;
	logic        stall;
	int          miscompares;
	int          compares;

	// Write, then read back
	fsps_row_t rows [8] = '{'{3'h0, 8'hff, 8'hff}, '{3'h1, 8'hff, 8'h7f},
		'{3'h2, 8'hff, 8'hff}, '{3'h3, 8'hff, 8'h3f}, '{3'h4, 8'hfc, 8'h7c},
		'{3'h5, 8'h55, 8'h00}, '{3'h6, 8'hff, 8'h00}, '{3'h4, 8'h00, 8'h00}};

	initial sys_clk = 1'b0;
	always #5 sys_clk = ~sys_clk;

	fsps_top #(.P_OP_CYCLES(OP_CYC)) u_dut
	(
		.I_SYS_CLK     (sys_clk),
		.I_RST         (rst),
		.I_ADDR        (addr),
		.I_WDATA       (wdata),
		.I_WR          (wr),
		.I_RD          (rd),
		.O_RDATA       (rdata),
		.I_FLASH_RDATA (flash_rdata),
		.O_FLASH_RD    (flash_rd),
		.O_FLASH_ADDR  (flash_addr),
		.O_FLASH_WDATA (flash_wdata),
		.O_CFG_SPACE   (cfg_space),
		.O_LATCH_LOAD  (latch_load),
		.O_PROG_START  (prog_start),
		.O_ERASE_START (erase_start),
		.O_FORCE_NOP   (force_nop),
		.O_STALL       (stall)
	);

	fsps_flash_model u_flash
	(
		.i_clk   (sys_clk),
		.i_rd    (flash_rd),
		.i_addr  (flash_addr),
		.o_rdata (flash_rdata)
	);

	// ****************************************
	// Checks and bus cycles
	// ****************************************
	task print_verdict;
		if (miscompares == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task chk_val(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp)
		begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task chk_bit(input logic got, input logic exp);
		compares++;
		if (got !== exp)
		begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task bus_wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge sys_clk);
		wr    <= 1'b0;
	endtask

	task bus_rd(input logic [2:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge sys_clk);
		rd   <= 1'b0;
		#1;
		chk_val({8'h00, rdata}, {8'h00, e});
	endtask

	// Key bytes, optional breaking strobe, then the control write
	task unlock(input logic [7:0] c, input logic brk);
		bus_wr(3'h5, 8'h55);
		if (brk)
			bus_rd(3'h5, 8'h00);
		bus_wr(3'h5, 8'haa);
		bus_wr(3'h4, c);
	endtask

	task quiet(input int n);
		repeat (n)
		begin
			@(posedge sys_clk);
			#1;
			chk_val({11'h0, force_nop, stall, latch_load, prog_start, erase_start}, 16'h0);
		end
	endtask

	// k = {latch, program, erase}
	task automatic op(input logic [7:0] c, input logic [2:0] k, input logic [14:0] ea,
		input int nstall);
		int n;
		unlock(c, 1'b0);
		#1;
		chk_val({14'h0, force_nop, latch_load}, {14'h0, 1'b1, k[2]});
		@(posedge sys_clk);
		#1;
		chk_val({13'h0, force_nop, latch_load, stall}, 16'h0004);
		@(posedge sys_clk);
		#1;
		chk_val({12'h0, prog_start, erase_start, stall, force_nop},
			{12'h0, k[1], k[0], nstall != 0, 1'b0});
		if (k[0])
			chk_val({1'b0, flash_addr}, {1'b0, ea[14:5], 5'h00});
		n = 0;
		while (stall === 1'b1 && n < 1000)
		begin
			n++;
			@(posedge sys_clk);
			#1;
		end
		if (n >= 1000)
		begin
			miscompares++;
			print_verdict;
		end
		chk_val(16'(n), 16'(nstall));
		chk_bit(force_nop, 1'b0);
	endtask

	// ****************************************
	// Sequence
	// ****************************************
	initial
	begin
		rst         = 1'b1;
		addr        = 3'h0;
		wdata       = 8'h00;
		wr          = 1'b0;
		rd          = 1'b0;
		miscompares = 0;
		compares    = 0;
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
		for (int i = 0; i < 8; i++)
			bus_rd(i[2:0], 8'h00);
		foreach (rows[i])
		begin
			bus_wr(rows[i].a, rows[i].w);
			bus_rd(rows[i].a, rows[i].e);
		end
		bus_wr(3'h4, 8'h40);
		#1;
		chk_bit(cfg_space, 1'b1);
		// Word read
		bus_wr(3'h0, 8'h34);
		bus_wr(3'h1, 8'h12);
		bus_wr(3'h4, 8'h01);
		#1;
		chk_bit(flash_rd, 1'b1);
		chk_bit(cfg_space, 1'b0);
		chk_val({1'b0, flash_addr}, 16'h1234);
		@(posedge sys_clk);
		#1;
		chk_val({14'h0, force_nop, flash_rd}, 16'h0002);
		@(posedge sys_clk);
		#1;
		chk_val({2'h0, flash_wdata}, 16'h3e6e);
		chk_bit(force_nop, 1'b0);
		bus_rd(3'h2, 8'h6e);
		bus_rd(3'h3, 8'h3e);
		bus_rd(3'h4, 8'h00);
		bus_wr(3'h2, 8'h5a);
		bus_rd(3'h2, 8'h5a);
		bus_rd(3'h3, 8'h3e);
		// Broken unlock, then write bit without write enable
		bus_wr(3'h4, 8'h14);
		unlock(8'h16, 1'b1);
		quiet(6);
		unlock(8'h12, 1'b0);
		quiet(6);
		bus_rd(3'h4, 8'h10);
		// Row erase, latch load, row program
		bus_wr(3'h0, 8'h37);
		bus_wr(3'h1, 8'h0a);
		bus_wr(3'h4, 8'h14);
		op(8'h16, 3'b001, 15'h0a37, OP_N);
		bus_rd(3'h4, 8'h14);
		bus_wr(3'h4, 8'h24);
		op(8'h26, 3'b100, 15'h0000, 0);
		bus_rd(3'h4, 8'h24);
		bus_wr(3'h4, 8'h04);
		op(8'h06, 3'b010, 15'h0000, OP_N);
		bus_wr(3'h4, 8'h34);
		op(8'h36, 3'b001, 15'h0a37, OP_N);
		bus_rd(3'h4, 8'h34);
		// Reset in mid-program
		bus_wr(3'h4, 8'h04);
		unlock(8'h06, 1'b0);
		repeat (5) @(posedge sys_clk);
		rst <= 1'b1;
		@(posedge sys_clk);
		rst <= 1'b0;
		#1;
		chk_bit(stall, 1'b0);
		bus_rd(3'h4, 8'h08);
		print_verdict;
	end
endmodule
